// file: idx_pkg.sv
// shared constants and types for the instruction execution slice
package idx_pkg;
   localparam int PC_W = 13;
   localparam int JMP_W = 11;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int OP_W = 14;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [DATA_W-1:0] ONE = 8'h01;
   localparam int DEST_BIT = 7;
   localparam int LATCH_HI = 4;
   localparam int LATCH_LO = 3;
   localparam logic [5:0] OPC_DECSKIP = 6'h0b;
   localparam logic [5:0] OPC_INCSKIP = 6'h0f;
   localparam logic [5:0] OPC_INC = 6'h0a;
   localparam logic [2:0] OPC_JMP = 3'h5;
   localparam logic [5:0] OPC_ORLIT = 6'h38;
   localparam logic [OP_W-1:0] OPC_NOP = 14'h0000;

   typedef enum logic [4:0] {
      IDX_OP_NONE = 5'b00001,
      IDX_OP_DECSKIP = 5'b00010,
      IDX_OP_INCSKIP = 5'b00100,
      IDX_OP_INC = 5'b01000,
      IDX_OP_JUMP_OR = 5'b10000
   } idx_op_type;

   typedef struct packed {
      logic we;
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } idx_fwr_type;
endpackage

// file: idx_alu.sv
// increment/decrement/or datapath with zero detect
`timescale 1ns/1ps
module idx_alu
   import idx_pkg::*;
(
   input wire logic [DATA_W-1:0] a,
   input wire logic [DATA_W-1:0] b,
   input wire logic [1:0] sel,
   output logic [DATA_W-1:0] res,
   output logic zero
);
   always_comb
   begin
      unique case (sel)
         2'h0: res = DATA_W'(a - ONE);
         2'h1: res = DATA_W'(a + ONE);
         default: res = a | b;
      endcase
      zero = (res == '0);
   end
endmodule

// file: idx_exec.sv
// executes the skip, increment, or-literal and jump instructions
`timescale 1ns/1ps
module idx_exec
   import idx_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [OP_W-1:0] instr,
   input wire logic [DATA_W-1:0] file_rdata,
   input wire logic [DATA_W-1:0] program_counter_high_latch,
   output logic [FADDR_W-1:0] file_raddr,
   output idx_fwr_type file_wr,
   output logic [PC_W-1:0] pc,
   output logic [DATA_W-1:0] acc,
   output logic zero_flag,
   output logic squash
);
   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] pc_nxt;
   logic [DATA_W-1:0] acc_r;
   logic [DATA_W-1:0] acc_nxt;
   logic zf_r;
   logic zf_nxt;
   logic squash_r;
   logic squash_nxt;
   idx_fwr_type fwr_r;
   idx_fwr_type fwr_nxt;
   idx_op_type op;
   logic [1:0] alu_sel;
   logic [DATA_W-1:0] alu_res;
   logic alu_zero;
   logic dest_file;
   logic is_jump;
   logic is_or;

   function automatic idx_op_type decode(input logic [OP_W-1:0] w);
      idx_op_type o;
      o = IDX_OP_NONE;
      if (w[OP_W-1:DATA_W] == OPC_DECSKIP)
         o = IDX_OP_DECSKIP;
      else if (w[OP_W-1:DATA_W] == OPC_INCSKIP)
         o = IDX_OP_INCSKIP;
      else if (w[OP_W-1:DATA_W] == OPC_INC)
         o = IDX_OP_INC;
      else if (w[OP_W-1:JMP_W] == OPC_JMP || w[OP_W-1:DATA_W] == OPC_ORLIT)
         o = IDX_OP_JUMP_OR;
      return o;
   endfunction

   assign op = decode(instr);
   assign is_jump = (op == IDX_OP_JUMP_OR) && (instr[OP_W-1:JMP_W] == OPC_JMP);
   assign is_or = (op == IDX_OP_JUMP_OR) && !is_jump;
   assign dest_file = instr[DEST_BIT];
   assign file_raddr = instr[FADDR_W-1:0];
   assign alu_sel = (op == IDX_OP_DECSKIP) ? 2'h0 : (is_or ? 2'h2 : 2'h1);

   idx_alu idx_alu_inst (
      .a(is_or ? acc_r : file_rdata),
      .b(instr[DATA_W-1:0]),
      .sel(alu_sel),
      .res(alu_res),
      .zero(alu_zero)
   );

   always_comb
   begin
      pc_nxt = PC_W'(pc_r + 1'b1);
      acc_nxt = acc_r;
      zf_nxt = zf_r;
      squash_nxt = 1'b0;
      fwr_nxt = '0;
      // a squashed slot only advances the program counter
      if (!squash_r)
      begin
         unique case (op)
            IDX_OP_DECSKIP, IDX_OP_INCSKIP, IDX_OP_INC:
            begin
               if (dest_file)
               begin
                  fwr_nxt.we = 1'b1;
                  fwr_nxt.addr = instr[FADDR_W-1:0];
                  fwr_nxt.data = alu_res;
               end
               else
                  acc_nxt = alu_res;
               // skip forms keep flags; only plain increment writes zero
               if (op == IDX_OP_INC)
                  zf_nxt = alu_zero;
               else
                  squash_nxt = alu_zero;
            end
            IDX_OP_JUMP_OR:
            begin
               if (is_jump)
               begin
                  pc_nxt = {program_counter_high_latch[LATCH_HI:LATCH_LO],
                            instr[JMP_W-1:0]};
                  // fetched word behind the jump is stale: second cycle
                  squash_nxt = 1'b1;
               end
               else
               begin
                  acc_nxt = alu_res;
                  zf_nxt = alu_zero;
               end
            end
            default:
            begin
               pc_nxt = PC_W'(pc_r + 1'b1);
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pc_r <= PC_RST;
         acc_r <= ACC_RST;
         zf_r <= 1'b0;
         squash_r <= 1'b0;
         fwr_r <= '0;
      end
      else
      begin
         pc_r <= pc_nxt;
         acc_r <= acc_nxt;
         zf_r <= zf_nxt;
         squash_r <= squash_nxt;
         fwr_r <= fwr_nxt;
      end
   end

   assign pc = pc_r;
   assign acc = acc_r;
   assign zero_flag = zf_r;
   assign squash = squash_r;
   assign file_wr = fwr_r;

   chk_skip_zero_squash: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && (op == IDX_OP_DECSKIP || op == IDX_OP_INCSKIP) && alu_zero)
      |=> squash_r)
      else $error("skip with zero result did not squash next slot");

   chk_skip_nonzero_run: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && (op == IDX_OP_DECSKIP || op == IDX_OP_INCSKIP) && !alu_zero)
      |=> !squash_r)
      else $error("nonzero skip result squashed next slot");

   chk_skip_flag_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && (op == IDX_OP_DECSKIP || op == IDX_OP_INCSKIP))
      |=> $stable(zero_flag))
      else $error("skip instruction changed zero flag");

   chk_dest_acc: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && op == IDX_OP_INCSKIP && !dest_file)
      |=> (acc == $past(DATA_W'(file_rdata + ONE))) && !file_wr.we)
      else $error("increment-skip to accumulator wrong");

   chk_dest_file: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && op == IDX_OP_DECSKIP && dest_file)
      |=> file_wr.we && file_wr.data == $past(DATA_W'(file_rdata - ONE)) && $stable(acc))
      else $error("decrement-skip file write wrong");

   chk_jump_target: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && is_jump)
      |=> pc == {$past(program_counter_high_latch[LATCH_HI:LATCH_LO]),
                 $past(instr[JMP_W-1:0])} && squash_r
         ##1 !squash_r)
      else $error("jump target or second cycle wrong");

   chk_jump_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && is_jump) |=> $stable(zero_flag) && $stable(acc))
      else $error("jump changed state");

   chk_or_literal: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && is_or)
      |=> acc == ($past(acc) | $past(instr[DATA_W-1:0])) && zero_flag == (acc == '0))
      else $error("or-literal result wrong");

   chk_inc_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && op == IDX_OP_INC)
      |=> zero_flag == ($past(DATA_W'(file_rdata + ONE)) == '0))
      else $error("increment zero flag wrong");

   chk_squash_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      squash_r |=> !file_wr.we && $stable(acc) && $stable(zero_flag)
         && pc == PC_W'($past(pc) + 1'b1))
      else $error("squashed slot had side effects");

   // skip decisions checked from the operand itself, not from the alu zero output
   chk_decskip_skip: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && op == IDX_OP_DECSKIP && file_rdata == ONE)
      |=> squash_r)
      else $error("decrement-skip reaching zero did not discard next slot");

   chk_incskip_skip: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && op == IDX_OP_INCSKIP && (&file_rdata))
      |=> squash_r)
      else $error("increment-skip wrapping to zero did not discard next slot");

   chk_skip_run_on: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && ((op == IDX_OP_DECSKIP && file_rdata != ONE)
         || (op == IDX_OP_INCSKIP && !(&file_rdata))))
      |=> !squash_r)
      else $error("nonzero skip result discarded next slot");

   chk_skip_pc_step: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && (op == IDX_OP_DECSKIP || op == IDX_OP_INCSKIP))
      |=> pc == PC_W'($past(pc) + 1'b1))
      else $error("skip instruction moved program counter wrongly");

   // destination routing for every read-modify-write form
   chk_decskip_acc: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && op == IDX_OP_DECSKIP && !dest_file)
      |=> acc == $past(DATA_W'(file_rdata - ONE)) && !file_wr.we)
      else $error("decrement-skip to accumulator wrong");

   chk_incskip_file: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && op == IDX_OP_INCSKIP && dest_file)
      |=> file_wr.we && file_wr.data == $past(DATA_W'(file_rdata + ONE))
         && $stable(acc))
      else $error("increment-skip file write wrong");

   chk_inc_file: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && op == IDX_OP_INC && dest_file)
      |=> file_wr.we && file_wr.data == $past(DATA_W'(file_rdata + ONE))
         && $stable(acc))
      else $error("increment file write wrong");

   chk_inc_acc: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && op == IDX_OP_INC && !dest_file)
      |=> acc == $past(DATA_W'(file_rdata + ONE)) && !file_wr.we)
      else $error("increment to accumulator wrong");

   chk_inc_no_skip: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && op == IDX_OP_INC)
      |=> !squash_r && pc == PC_W'($past(pc) + 1'b1))
      else $error("plain increment skipped or jumped");

   chk_write_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && dest_file
         && (op == IDX_OP_DECSKIP || op == IDX_OP_INCSKIP || op == IDX_OP_INC))
      |=> file_wr.addr == $past(instr[FADDR_W-1:0]))
      else $error("file write went to wrong address");

   chk_write_acc_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && dest_file
         && (op == IDX_OP_DECSKIP || op == IDX_OP_INCSKIP || op == IDX_OP_INC))
      |=> file_wr.we && $stable(acc))
      else $error("file destination disturbed accumulator");

   // jump target split into its two sources
   chk_jump_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && is_jump)
      |=> pc[JMP_W-1:0] == $past(instr[JMP_W-1:0]) && !file_wr.we)
      else $error("jump low target bits wrong");

   chk_jump_high: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && is_jump)
      |=> pc[PC_W-1:JMP_W] == $past(program_counter_high_latch[LATCH_HI:LATCH_LO]))
      else $error("jump high target bits wrong");

   chk_jump_resume: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && is_jump)
      |=> ##1 pc == PC_W'($past(pc) + 1'b1) && $stable(zero_flag))
      else $error("jump second cycle did not resume at target");

   chk_or_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && is_or)
      |=> !file_wr.we && !squash_r && pc == PC_W'($past(pc) + 1'b1))
      else $error("or-literal touched file or flow");

   chk_or_sets_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && is_or)
      |=> (acc | $past(instr[DATA_W-1:0])) == acc)
      else $error("or-literal lost a literal bit");

   // undecoded words behave as a no-op
   chk_nop_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!squash_r && (op == IDX_OP_NONE || instr == OPC_NOP))
      |=> !file_wr.we && !squash_r && $stable(acc) && $stable(zero_flag)
         && pc == PC_W'($past(pc) + 1'b1))
      else $error("no-op slot had side effects");

   chk_squash_single: assert property (@(posedge core_clk) disable iff (!rst_n)
      squash_r |=> !squash_r)
      else $error("discarded slot discarded the next one too");

   // a stale jump word in a discarded slot must not redirect the program counter
   chk_squashed_jump: assert property (@(posedge core_clk) disable iff (!rst_n)
      (squash_r && instr[OP_W-1:JMP_W] == OPC_JMP)
      |=> !squash_r && pc == PC_W'($past(pc) + 1'b1))
      else $error("discarded jump changed program flow");
endmodule

// file: tb_idx_exec.sv
// random self-checking bench for the instruction execution slice
`timescale 1ns/1ps
module tb_idx_exec
   import idx_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [OP_W-1:0] instr = '0;
   logic [DATA_W-1:0] file_rdata = '0;
   logic [DATA_W-1:0] latch = '0;
   logic [FADDR_W-1:0] file_raddr;
   idx_fwr_type file_wr;
   logic [PC_W-1:0] pc;
   logic [DATA_W-1:0] acc;
   logic zero_flag;
   logic squash;
   int miscompares = 0;
   int num_checks = 0;
   logic [PC_W-1:0] m_pc;
   logic [DATA_W-1:0] m_acc;
   logic m_z;
   logic m_sq;
   idx_fwr_type m_wr;

   always #10 core_clk = ~core_clk;

   idx_exec idx_exec_inst (.core_clk(core_clk), .rst_n(rst_n), .instr(instr),
      .file_rdata(file_rdata), .program_counter_high_latch(latch), .file_raddr(file_raddr),
      .file_wr(file_wr), .pc(pc), .acc(acc), .zero_flag(zero_flag), .squash(squash));

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         miscompares++;
      end
   endtask

   task end_sim;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   function void model_reset();
      m_pc = PC_RST;
      m_acc = ACC_RST;
      m_z = 1'b0;
      m_sq = 1'b0;
      m_wr = '0;
   endfunction

   // expected state after the coming edge, from the inputs just driven
   function void model_step();
      logic [DATA_W-1:0] res;
      res = (instr[13:8] == OPC_DECSKIP) ? file_rdata - ONE : file_rdata + ONE;
      m_wr.we = 1'b0;
      m_pc = m_pc + 13'h0001;
      if (m_sq)
         m_sq = 1'b0;
      else if (instr[13:11] == OPC_JMP)
      begin
         m_pc = {latch[LATCH_HI:LATCH_LO], instr[JMP_W-1:0]};
         m_sq = 1'b1;
      end
      else if (instr[13:8] == OPC_ORLIT)
      begin
         m_acc = m_acc | instr[7:0];
         m_z = (m_acc == 8'h00);
      end
      else if (instr[13:8] inside {OPC_DECSKIP, OPC_INCSKIP, OPC_INC})
      begin
         if (instr[DEST_BIT])
            m_wr = {1'b1, instr[FADDR_W-1:0], res};
         else
            m_acc = res;
         if (instr[13:8] == OPC_INC)
            m_z = (res == 8'h00);
         else
            m_sq = (res == 8'h00);
      end
   endfunction

   task check_all;
      chk(16'(pc), 16'(m_pc));
      chk(16'(acc), 16'(m_acc));
      chk(16'(zero_flag), 16'(m_z));
      chk(16'(squash), 16'(m_sq));
      chk(16'(file_raddr), 16'(instr[FADDR_W-1:0]));
      chk(16'(file_wr.we), 16'(m_wr.we));
      if (m_wr.we)
         chk(16'(file_wr), 16'(m_wr));
   endtask

   task run_one(input logic [OP_W-1:0] i, input logic [7:0] r, input logic [7:0] l,
                input logic rs);
      @(negedge core_clk);
      check_all();
      instr = i;
      file_rdata = r;
      latch = l;
      rst_n = rs;
      if (rs)
         model_step();
      else
         model_reset();
   endtask

   // zero literals and edge data values are favoured to reach the zero cases
   function logic [OP_W-1:0] pick();
      logic [7:0] lo;
      lo = ($urandom_range(3) == 0) ? 8'h00 : 8'($urandom());
      case ($urandom_range(5))
         0: return {OPC_DECSKIP, lo};
         1: return {OPC_INCSKIP, lo};
         2: return {OPC_INC, lo};
         3: return {OPC_ORLIT, lo};
         4: return {OPC_JMP, 11'($urandom())};
         default: return 14'($urandom());
      endcase
   endfunction

   function logic [7:0] pick_data();
      case ($urandom_range(3))
         0: return 8'h01;
         1: return 8'hff;
         2: return 8'h00;
         default: return 8'($urandom());
      endcase
   endfunction

   initial
   begin
      model_reset();
      void'($urandom(32'hf4d6));
      repeat (8) @(posedge core_clk);
      run_one(14'h2fff, 8'h01, 8'h18, 1'b1); // jump to the very top, pc wraps after
      run_one(14'h0a05, 8'h7f, 8'h00, 1'b1);
      run_one(14'h0b85, 8'h01, 8'h00, 1'b1);
      run_one(14'h3800, 8'h00, 8'h00, 1'b1);
      run_one(14'h0f00, 8'hff, 8'h00, 1'b1);
      run_one(14'h3800, 8'h00, 8'h00, 1'b1);
      run_one(14'h3800, 8'h00, 8'h00, 1'b1);
      run_one(14'h0f80, 8'h05, 8'h00, 1'b1);
      run_one(14'h0a85, 8'hff, 8'h00, 1'b1);
      run_one(14'h3855, 8'h00, 8'h00, 1'b1);
      run_one(14'h0b00, 8'h01, 8'h00, 1'b0);
      repeat (800) run_one(pick(), pick_data(), 8'($urandom()), $urandom_range(63) != 0);
      // second call checks the result of the first no-op
      repeat (2) run_one(14'h0000, 8'h00, 8'h00, 1'b1);
      end_sim();
   end
endmodule
